/* hdl/arp_frame_field_matcher.sv */
// Design: one filter entry deciding whether an ARP or RARP frame hits it
module arp_frame_field_matcher (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Frame side
  input wire logic hdr_valid,
  input wire arp_match_pkg::arp_hdr_t hdr,
  output logic hit_valid,
  output logic hit,
  // AXI4-Lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Three-way test: Any passes, otherwise the setting selects equal or not
  function automatic logic test3(input logic [1:0] sel, input logic eq);
    if (sel[1])
      test3 = 1'b1; // [R5]
    else
      test3 = (sel == arp_match_pkg::SET_IS) ? eq : !eq;
  endfunction : test3

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction : merge

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] hits_q, hits_d;
  logic hit_valid_q, hit_valid_d, hit_q, hit_d;
  logic aw_q, aw_d, w_q, w_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic match;

  // --------------------------------------------------------------------------
  // Classification
  // --------------------------------------------------------------------------
  // All tests combined; a non-ARP entry ignores the ARP fields entirely
  always_comb
  begin
    logic sha_ok, tha_ok, len_ok, hrd_ok, pro_ok;
    sha_ok = 1'b1;
    tha_ok = 1'b1;
    len_ok = 1'b1;
    hrd_ok = 1'b1;
    pro_ok = 1'b1;
    // Sender test only concerns ARP frames, target test only RARP frames
    if (!hdr.is_rarp)
      sha_ok = test3(ctrl_q[arp_match_pkg::CTRL_SHA +: 2],
                     hdr.sender_hw == hdr.frame_source_mac); // [R1]
    else
      tha_ok = test3(ctrl_q[arp_match_pkg::CTRL_THA +: 2],
                     hdr.target_hw == hdr.frame_source_mac); // [R2]
    len_ok = test3(ctrl_q[arp_match_pkg::CTRL_LEN +: 2],
                   hdr.hw_len == arp_match_pkg::HLEN_ETH &&
                   hdr.proto_len == arp_match_pkg::PLEN_IPV4); // [R3]
    hrd_ok = test3(ctrl_q[arp_match_pkg::CTRL_HRD +: 2],
                   hdr.hardware_space_field == arp_match_pkg::HSPACE_ETH); // [R4]
    pro_ok = test3(ctrl_q[arp_match_pkg::CTRL_PRO +: 2],
                   hdr.proto_space == arp_match_pkg::PSPACE_IPV4); // [R6] [R7]
    if (ctrl_q[arp_match_pkg::CTRL_ARPTYPE])
      match = sha_ok && tha_ok && len_ok && hrd_ok && pro_ok;
    else
      match = 1'b1; // [R8]
  end

  // Result and hit counter; a disabled entry never hits
  always_comb
  begin
    hit_valid_d = hdr_valid;
    hit_d = hdr_valid && match && ctrl_q[arp_match_pkg::CTRL_EN];
    hits_d = hits_q + {31'h0000_0000, hit_d};
    if (bvalid_d && !bvalid_q && awaddr_d == arp_match_pkg::OFF_HITS)
      hits_d = 32'h0000_0000; // Any write to OFF_HITS clears; a hit in that cycle is dropped
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data taken in either order; response once both are held
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    if (s_awvalid && !aw_q && !bvalid_q)
    begin
      aw_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && !w_q && !bvalid_q)
    begin
      w_d = 1'b1;
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (aw_d && w_d && !bvalid_q)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = arp_match_pkg::RESP_OKAY;
      unique case (awaddr_d)
        arp_match_pkg::OFF_CTRL: ctrl_d = merge(ctrl_q, wdata_d, wstrb_d) & 32'h0000_0FFF;
        arp_match_pkg::OFF_HITS: ;
        default: bresp_d = arp_match_pkg::RESP_SLVERR;
      endcase
    end
    else if (bvalid_q && s_bready)
      bvalid_d = 1'b0;
    // Readies from flops; loaded from the next state, so they match the held state in the same cycle
    awready_d = !aw_d && !bvalid_d;
    wready_d = !w_d && !bvalid_d;
  end

  // Read channel: one cycle to answer, held until taken
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_rready)
      rvalid_d = 1'b0;
    else if (s_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = arp_match_pkg::RESP_OKAY;
      unique case (s_araddr)
        arp_match_pkg::OFF_CTRL: rdata_d = ctrl_q;
        arp_match_pkg::OFF_STAT: rdata_d = {30'h0000_0000, hit_q, match};
        arp_match_pkg::OFF_HITS: rdata_d = hits_q;
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = arp_match_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Registers; clk_en low freezes everything
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q <= arp_match_pkg::CTRL_RESET;
      hits_q <= 32'h0000_0000;
      hit_valid_q <= 1'b0;
      hit_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end
    else if (clk_en)
    begin
      ctrl_q <= ctrl_d;
      hits_q <= hits_d;
      hit_valid_q <= hit_valid_d;
      hit_q <= hit_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign hit_valid = hit_valid_q;
  assign hit = hit_q;
  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  wire logic armed = clk_en && hdr_valid && ctrl_q[arp_match_pkg::CTRL_EN]
                     && ctrl_q[arp_match_pkg::CTRL_ARPTYPE];
  wire logic [1:0] sha_set = ctrl_q[arp_match_pkg::CTRL_SHA +: 2];
  wire logic [1:0] tha_set = ctrl_q[arp_match_pkg::CTRL_THA +: 2];
  wire logic [1:0] len_set = ctrl_q[arp_match_pkg::CTRL_LEN +: 2];
  wire logic [1:0] hrd_set = ctrl_q[arp_match_pkg::CTRL_HRD +: 2];
  wire logic [1:0] pro_set = ctrl_q[arp_match_pkg::CTRL_PRO +: 2];
  wire logic len_fit = hdr.hw_len == arp_match_pkg::HLEN_ETH
                     && hdr.proto_len == arp_match_pkg::PLEN_IPV4;

  a_sha_equal: assert property (@(posedge clock) disable iff (rst) // [R1]
    armed && !hdr.is_rarp && sha_set == arp_match_pkg::SET_IS
    && hdr.sender_hw != hdr.frame_source_mac |=> !hit)
    else $error("sender test passed a mismatching frame");
  a_tha_differ: assert property (@(posedge clock) disable iff (rst) // [R2]
    armed && hdr.is_rarp && tha_set == arp_match_pkg::SET_NOT
    && hdr.target_hw == hdr.frame_source_mac |=> !hit)
    else $error("target test passed an equal frame");
  a_len_qualify: assert property (@(posedge clock) disable iff (rst) // [R3]
    armed && len_set == arp_match_pkg::SET_IS && !len_fit |=> !hit)
    else $error("length test passed a non qualifying frame");
  a_len_exclude: assert property (@(posedge clock) disable iff (rst) // [R3]
    armed && len_set == arp_match_pkg::SET_NOT && len_fit |=> !hit)
    else $error("length test passed a qualifying frame");
  a_hrd_space: assert property (@(posedge clock) disable iff (rst) // [R4]
    armed && hrd_set == arp_match_pkg::SET_NOT
    && hdr.hardware_space_field == arp_match_pkg::HSPACE_ETH |=> !hit)
    else $error("hardware space test passed an excluded frame");
  a_all_any: assert property (@(posedge clock) disable iff (rst) // [R5]
    armed && sha_set[1] && tha_set[1] && len_set[1] && hrd_set[1] && pro_set[1]
    |=> hit && hit_valid)
    else $error("all don't-care entry missed a frame");
  a_pro_space: assert property (@(posedge clock) disable iff (rst) // [R7]
    armed && pro_set == arp_match_pkg::SET_IS
    && hdr.proto_space != arp_match_pkg::PSPACE_IPV4 |=> !hit)
    else $error("protocol space test passed a wrong frame");
  a_non_arp: assert property (@(posedge clock) disable iff (rst) // [R8]
    clk_en && hdr_valid && ctrl_q[arp_match_pkg::CTRL_EN]
    && !ctrl_q[arp_match_pkg::CTRL_ARPTYPE] |=> hit)
    else $error("non ARP entry applied ARP field tests");

endmodule : arp_frame_field_matcher

/* inc/arp_match_pkg.sv */
// Package: constants, types and register map for the ARP field matcher
// ----------------------------------------------------------------------------
// How it works
// [R1] Sender address test: 0 needs sender different from source MAC, 1 equal.
// [R2] Target address test: 0 needs target different from source MAC, 1 equal.
// [R3] Length test: qualifying means hardware length 6 and protocol length 4.
// [R4] Hardware space test: setting 1 needs field 1, setting 0 excludes it.
// [R5] Any setting makes a test don't-care; it never blocks a hit.
// [R6] A protocol space test also takes part in the hit decision.
// [R7] Protocol space compares against 0x0800 with the same three settings.
// [R8] ARP field tests apply only when the entry's frame type is ARP.
// ----------------------------------------------------------------------------
package arp_match_pkg;

  // --------------------------------------------------------------------------
  // Field values and settings
  // --------------------------------------------------------------------------
  localparam logic [7:0] HLEN_ETH = 8'h06;
  localparam logic [7:0] PLEN_IPV4 = 8'h04;
  localparam logic [15:0] HSPACE_ETH = 16'h0001;
  localparam logic [15:0] PSPACE_IPV4 = 16'h0800;

  // Two-bit setting code: 0, 1, Any (3 also treated as Any)
  localparam logic [1:0] SET_NOT = 2'h0;
  localparam logic [1:0] SET_IS = 2'h1;
  localparam logic [1:0] SET_ANY = 2'h2;

  // --------------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_HITS = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0AAA;
  // Control bit positions
  localparam int CTRL_SHA = 0;
  localparam int CTRL_THA = 2;
  localparam int CTRL_LEN = 4;
  localparam int CTRL_HRD = 6;
  localparam int CTRL_PRO = 8;
  localparam int CTRL_ARPTYPE = 10;
  localparam int CTRL_EN = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------------
  // Frame header carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [47:0] frame_source_mac;
    logic [15:0] hardware_space_field;
    logic [15:0] proto_space;
    logic [7:0] hw_len;
    logic [7:0] proto_len;
    logic is_rarp;
    logic [47:0] sender_hw;
    logic [47:0] target_hw;
  } arp_hdr_t;

endpackage : arp_match_pkg

/* bench/frame_source.sv */
// Frame source model: presents one received header per send request
module frame_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic send,
  input wire arp_match_pkg::arp_hdr_t hdr_in,
  output logic hdr_valid,
  output arp_match_pkg::arp_hdr_t hdr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines flip every cycle, so a stale header never passes for a frame
  always_ff @(posedge clock)
    if (rst)
    begin
      hdr_valid <= 1'b0;
      hdr <= '0;
    end
    else
    begin
      hdr_valid <= send;
      hdr <= send ? hdr_in : ~hdr;
    end
endmodule : frame_source

/* bench/test_arp_frame_field_matcher.sv */
// Testbench: field tests, register access and hit count of the ARP matcher
module test_arp_frame_field_matcher;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] ctrl; logic [5:0] flags; logic exp;} row_t;
  localparam logic [47:0] MAC = 48'h0A0B_0C0D_0E0F;
  logic clock = 1'b0, rst = 1'b1, send = 1'b0, hdr_valid, hit_valid, hit;
  arp_match_pkg::arp_hdr_t hdr_in = '0, hdr;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hF;
  logic clk_en = 1'b1;
  logic [31:0] s_wdata = 32'h0, s_rdata, d;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, n_hits = 0;
  // Flags: 0 sender eq, 1 target eq, 2 lengths ok, 3 hw space eth, 4 proto ipv4, 5 rarp
  row_t rows [20] = '{
    '{12'hEAA, 6'h00, 1'b1}, '{12'hEA9, 6'h1F, 1'b1}, '{12'hEA9, 6'h1E, 1'b0},
    '{12'hEA8, 6'h1F, 1'b0}, '{12'hEA8, 6'h1E, 1'b1}, '{12'hEA6, 6'h3F, 1'b1},
    '{12'hEA2, 6'h3F, 1'b0}, '{12'hEA2, 6'h3D, 1'b1}, '{12'hE9A, 6'h1F, 1'b1},
    '{12'hE9A, 6'h1B, 1'b0}, '{12'hE8A, 6'h1F, 1'b0}, '{12'hE6A, 6'h1F, 1'b1},
    '{12'hE2A, 6'h1F, 1'b0}, '{12'hE6A, 6'h17, 1'b0}, '{12'hDAA, 6'h1F, 1'b1},
    '{12'hCAA, 6'h1F, 1'b0}, '{12'hCAA, 6'h0F, 1'b1}, '{12'hAA9, 6'h1E, 1'b1},
    '{12'hDAA, 6'h0F, 1'b0}, '{12'h6AA, 6'h1F, 1'b0}};
  frame_source u_frame_source (.clock(clock), .rst(rst), .send(send), .hdr_in(hdr_in),
    .hdr_valid(hdr_valid), .hdr(hdr));
  arp_frame_field_matcher u_arp_frame_field_matcher (.clock(clock), .rst(rst), .clk_en(clk_en),
    .hdr_valid(hdr_valid), .hdr(hdr), .hit_valid(hit_valid), .hit(hit),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  // Clock and hang guard; the ceiling is far above the few hundred cycles the run needs
  initial
    forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  // Address and data offered together, each dropped once taken, bready up until bvalid
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid)
      begin
        resp = s_bresp;
        s_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid)
      begin
        v = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read
  function automatic arp_match_pkg::arp_hdr_t mk(input logic [5:0] f);
    arp_match_pkg::arp_hdr_t h;
    h.frame_source_mac = MAC;
    h.sender_hw = f[0] ? MAC : ~MAC;
    h.target_hw = f[1] ? MAC : MAC ^ 48'h1;
    h.hw_len = f[2] ? 8'h06 : 8'h10;
    h.proto_len = 8'h04;
    h.hardware_space_field = f[3] ? 16'h0001 : 16'h0006;
    h.proto_space = f[4] ? 16'h0800 : 16'h86DD;
    h.is_rarp = f[5];
    return h;
  endfunction : mk
  // One frame through the partner, answer checked in its single valid cycle
  task automatic send_frame(input logic [5:0] f, input logic exp);
    @(posedge clock);
    send <= 1'b1;
    hdr_in <= mk(f);
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock) #1;
    cmp_bit(hit_valid, 1'b1);
    cmp_bit(hit, exp);
    @(posedge clock) #1;
    cmp_bit(hit_valid, 1'b0);
  endtask : send_frame
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset
  initial
  begin
    do_reset();
    axi_read(arp_match_pkg::OFF_CTRL, d, r);
    cmp_word(d, 32'h0000_0AAA);
    foreach (rows[i])
    begin
      axi_write(arp_match_pkg::OFF_CTRL, {20'h0, rows[i].ctrl}, r);
      cmp_word({30'h0, r}, 32'h0);
      send_frame(rows[i].flags, rows[i].exp);
      if (rows[i].exp) n_hits++;
    end
    // Register side: read-back, count, clear, refusals
    axi_read(arp_match_pkg::OFF_CTRL, d, r);
    cmp_word(d, 32'h0000_06AA);
    axi_read(arp_match_pkg::OFF_STAT, d, r);
    cmp_word(d, 32'h0000_0001);
    axi_read(arp_match_pkg::OFF_HITS, d, r);
    cmp_word(d, n_hits);
    axi_write(arp_match_pkg::OFF_HITS, 32'h0, r);
    cmp_word({30'h0, r}, 32'h0);
    axi_read(arp_match_pkg::OFF_HITS, d, r);
    cmp_word(d, 32'h0);
    axi_write(arp_match_pkg::OFF_STAT, 32'hFFFF_FFFF, r);
    cmp_word({30'h0, r}, 32'h2);
    axi_read(4'hC, d, r);
    cmp_word({d[29:0], r}, 32'h2);
    // Byte strobes: only the low lane of the control word may change
    s_wstrb <= 4'h1;
    axi_write(arp_match_pkg::OFF_CTRL, 32'hFFFF_FF55, r);
    s_wstrb <= 4'hF;
    axi_read(arp_match_pkg::OFF_CTRL, d, r);
    cmp_word(d, 32'h0000_0655);
    // Enable low: a frame offered while frozen must never be taken
    clk_en <= 1'b0;
    @(posedge clock);
    send <= 1'b1;
    hdr_in <= mk(6'h1F);
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock) #1;
    cmp_bit(hit_valid, 1'b0);
    @(posedge clock);
    clk_en <= 1'b1;
    // Reset in mid-run returns the control word to all-Any
    do_reset();
    axi_read(arp_match_pkg::OFF_CTRL, d, r);
    cmp_word(d, 32'h0000_0AAA);
    end_sim();
  end
endmodule : test_arp_frame_field_matcher
